//--- rtl/dts_pkg.sv
package dts_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int CH_N = 4;
  localparam int ADDR_W = 16;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [3:0] MASK_RST = 4'hf;
  localparam logic [1:0] LAST_RST = 2'h3;
  localparam logic [3:0] SWREQ_RST = 4'h0;
  localparam logic [15:0] CNT_LAST = 16'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] PIN_LO_RST = 2'h0;
  localparam logic [1:0] PIN_HI_RST = 2'h3;

  // ----------------------------------------------------------------
  // transfer types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TYP_VERIFY = 2'b00,
    TYP_WRITE = 2'b01,
    TYP_READ = 2'b10,
    TYP_SPARE = 2'b11
  } dts_type_t;

  // ----------------------------------------------------------------
  // transfer modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MOD_DEMAND = 2'b00,
    MOD_SINGLE = 2'b01,
    MOD_BLOCK = 2'b10,
    MOD_CASCADE = 2'b11
  } dts_mode_t;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REQ = 3'b001,
    ST_ADR = 3'b010,
    ST_RD = 3'b011,
    ST_WR = 3'b100,
    ST_WAIT = 3'b101,
    ST_END = 3'b110,
    ST_CASC = 3'b111
  } dts_state_t;

endpackage

//--- rtl/dts_top.sv
`timescale 1ns/10ps
module dts_top (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  // configuration
  input wire logic I_ENABLE,
  input wire logic I_PRIO_ROTATE,
  input wire logic I_EXT_WRITE,
  input wire logic I_COMPRESSED,
  input wire logic I_MEM2MEM,
  input wire dts_pkg::dts_type_t I_TYPE [dts_pkg::CH_N],
  input wire dts_pkg::dts_mode_t I_MODE [dts_pkg::CH_N],
  input wire logic [dts_pkg::CH_N-1:0] I_AUTO_INIT,
  input wire logic [dts_pkg::CH_N-1:0] I_ADDR_DEC,
  // programming strobes
  input wire logic I_PROG_WR,
  input wire logic [1:0] I_PROG_CH,
  input wire logic [dts_pkg::ADDR_W-1:0] I_PROG_ADDR,
  input wire logic [dts_pkg::CNT_W-1:0] I_PROG_COUNT,
  input wire logic I_MASK_WR,
  input wire logic [dts_pkg::CH_N-1:0] I_MASK_VAL,
  input wire logic [dts_pkg::CH_N-1:0] I_SW_REQ,
  // pins
  input wire logic [dts_pkg::CH_N-1:0] I_CH_REQ,
  input wire logic I_HOLD_GRANT,
  input wire logic I_READY,
  input wire logic I_EOP_IN,
  input wire logic [dts_pkg::BYTE_W-1:0] I_DATA_IN,
  output logic O_HOLD_REQ,
  output logic O_ADDR_EN,
  output logic O_ADDR_STB,
  output logic [dts_pkg::CH_N-1:0] O_CH_ACK,
  output logic [dts_pkg::BYTE_W-1:0] O_ADDR_LO,
  output logic O_ADDR_LO_OE,
  output logic [dts_pkg::BYTE_W-1:0] O_DATA_OUT,
  output logic O_DATA_OE,
  output logic O_MEM_RD_B,
  output logic O_MEM_WR_B,
  output logic O_IO_RD_B,
  output logic O_IO_WR_B,
  output logic O_STROBE_OE,
  output logic O_EOP_OUT,
  output logic O_EOP_OE,
  output logic O_TERMINAL_COUNT,
  output logic [dts_pkg::CH_N-1:0] O_MASK
);
  import dts_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [CH_N-1:0] req_m, req_s;
  logic grant_m, grant_s, ready_m, ready_s, eop_m, eop_s;
  logic [BYTE_W-1:0] din_m, din_s;
  dts_state_t state_q, state_d;
  logic [1:0] chan_q, chan_d, last_q, win;
  logic win_ok;
  logic m2m_q, m2m_d, phase_q, phase_d;
  logic [ADDR_W-1:0] cur_addr_q [CH_N];
  logic [ADDR_W-1:0] base_addr_q [CH_N];
  logic [CNT_W-1:0] cur_cnt_q [CH_N];
  logic [CNT_W-1:0] base_cnt_q [CH_N];
  logic [CH_N-1:0] mask_q, sw_q, pend;
  logic [BYTE_W-1:0] temp_q;
  logic eop_seen_q;
  logic [1:0] act_q, act_d;
  logic [ADDR_W-1:0] addr_nxt, addr_out;
  logic cnt_zero, tc_now, tc_evt, hi_same, verify_q, cascade_w;
  logic xfer_d, rd_on, wr_on, tc_pred;
  dts_type_t typ_d;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two stages for every pin before logic sees it
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      req_m <= SWREQ_RST;
      req_s <= SWREQ_RST;
      {grant_m, grant_s} <= PIN_LO_RST; // grant pin idles low
      {ready_m, ready_s} <= PIN_HI_RST; // ready and end pins idle high
      {eop_m, eop_s} <= PIN_HI_RST;
      din_m <= BYTE_RST;
      din_s <= BYTE_RST;
    end else begin
      req_m <= I_CH_REQ;
      req_s <= req_m;
      grant_m <= I_HOLD_GRANT;
      grant_s <= grant_m;
      ready_m <= I_READY;
      ready_s <= ready_m;
      eop_m <= I_EOP_IN;
      eop_s <= eop_m;
      din_m <= I_DATA_IN;
      din_s <= din_m;
    end
  end

  // ----------------------------------------------------------------
  // priority resolution
  // ----------------------------------------------------------------
  // search starts after the last serviced channel when rotating
  always_comb begin
    logic [1:0] c;
    c = 2'h0;
    win = 2'h0;
    win_ok = 1'b0;
    pend = (req_s & ~mask_q) | sw_q;
    for (int i = 0; i < CH_N; i++) begin
      c = I_PRIO_ROTATE ? last_q + 2'(i + 1) : 2'(i);
      if (!win_ok && pend[c]) begin
        win = c;
        win_ok = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // word arithmetic of the active channel
  // ----------------------------------------------------------------
  assign act_q = m2m_q ? {1'b0, phase_q} : chan_q;
  assign act_d = m2m_d ? {1'b0, phase_d} : chan_d;
  // step by one in the programmed direction
  assign addr_nxt = I_ADDR_DEC[act_q] ? cur_addr_q[act_q] - 16'h0001 : cur_addr_q[act_q] + 16'h0001;
  assign cnt_zero = cur_cnt_q[act_q] == CNT_LAST;
  assign tc_now = cnt_zero || eop_seen_q;
  assign tc_evt = (state_q == ST_END) && tc_now && !(m2m_q && !phase_q);
  assign hi_same = addr_nxt[15:8] == cur_addr_q[act_q][15:8];
  assign verify_q = (I_TYPE[chan_q] == TYP_VERIFY) && !m2m_q;
  assign cascade_w = I_MODE[win] == MOD_CASCADE;

  // ----------------------------------------------------------------
  // state sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    chan_d = chan_q;
    m2m_d = m2m_q;
    phase_d = phase_q;
    unique case (state_q)
      ST_IDLE: begin
        // a grant still high means the previous release is not seen yet
        if (I_ENABLE && (|pend) && !grant_s) begin
          state_d = ST_REQ;
        end
      end
      ST_REQ: begin
        if (grant_s && win_ok) begin
          chan_d = win;
          m2m_d = I_MEM2MEM && (win == 2'h0);
          phase_d = 1'b0;
          state_d = cascade_w && !(I_MEM2MEM && win == 2'h0) ? ST_CASC : ST_ADR;
        end
      end
      ST_CASC: begin
        // only the request ends it; the end pin is not looked at
        if (!req_s[chan_q] && !sw_q[chan_q]) begin
          state_d = ST_IDLE;
        end
      end
      ST_ADR: begin
        state_d = ST_RD;
      end
      ST_RD: begin
        if (I_COMPRESSED && !m2m_q) begin
          state_d = (ready_s || verify_q) ? ST_END : ST_WAIT;
        end else begin
          state_d = ST_WR;
        end
      end
      ST_WR: begin
        state_d = (ready_s || verify_q) ? ST_END : ST_WAIT;
      end
      ST_WAIT: begin
        if (ready_s) begin
          state_d = ST_END;
        end
      end
      ST_END: begin
        if (m2m_q) begin
          phase_d = !phase_q;
          state_d = (phase_q && tc_now) ? ST_IDLE : ST_ADR;
        end else if (tc_now || I_MODE[chan_q] == MOD_SINGLE) begin
          state_d = ST_IDLE;
        end else if (I_MODE[chan_q] == MOD_BLOCK || req_s[chan_q]) begin
          state_d = hi_same ? ST_RD : ST_ADR;
        end else begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // state and channel registers
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_q <= ST_IDLE;
      chan_q <= 2'h0;
      m2m_q <= 1'b0;
      phase_q <= 1'b0;
    end else begin
      state_q <= state_d;
      chan_q <= chan_d;
      m2m_q <= m2m_d;
      phase_q <= phase_d;
    end
  end

  // last serviced channel for rotation
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      last_q <= LAST_RST;
    end else if (state_q == ST_REQ && state_d != ST_REQ) begin
      last_q <= win;
    end
  end

  // external end pulse caught in the ST_ADR and ST_RD states
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      eop_seen_q <= 1'b0;
    end else if ((state_q == ST_ADR || state_q == ST_RD) && !eop_s) begin
      eop_seen_q <= 1'b1;
    end else if (state_q == ST_IDLE) begin
      eop_seen_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // per channel address and count registers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < CH_N; g++) begin : g_ch
    logic reload, step;
    assign reload = tc_evt && I_AUTO_INIT[g] && (act_q == 2'(g) || (m2m_q && g < 2));
    assign step = (state_q == ST_END) && (act_q == 2'(g));
    // load base and current together, reload or step after each word
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
        cur_addr_q[g] <= WORD_RST;
        base_addr_q[g] <= WORD_RST;
        cur_cnt_q[g] <= WORD_RST;
        base_cnt_q[g] <= WORD_RST;
      end else if (I_PROG_WR && state_q == ST_IDLE && I_PROG_CH == 2'(g)) begin
        cur_addr_q[g] <= I_PROG_ADDR;
        base_addr_q[g] <= I_PROG_ADDR;
        cur_cnt_q[g] <= I_PROG_COUNT;
        base_cnt_q[g] <= I_PROG_COUNT;
      end else if (reload) begin
        cur_addr_q[g] <= base_addr_q[g];
        cur_cnt_q[g] <= base_cnt_q[g];
      end else if (step) begin
        cur_addr_q[g] <= addr_nxt;
        cur_cnt_q[g] <= cur_cnt_q[g] - 16'h0001;
      end
    end

    // terminal count sets the mask unless auto init; set wins over write
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
        mask_q[g] <= MASK_RST[g];
      end else if (tc_evt && !I_AUTO_INIT[g] && (act_q == 2'(g) || (m2m_q && g < 2))) begin
        mask_q[g] <= 1'b1;
      end else if (I_MASK_WR) begin
        mask_q[g] <= I_MASK_VAL[g];
      end
    end

    // software request held until any channel's operation ends
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
        sw_q[g] <= SWREQ_RST[g];
      end else if (I_SW_REQ[g]) begin
        sw_q[g] <= 1'b1;
      end else if (state_q != ST_IDLE && state_q != ST_REQ && state_d == ST_IDLE) begin
        sw_q[g] <= 1'b0;
      end
    end
  end

  // temporary byte captured at the end of the read half
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      temp_q <= BYTE_RST;
    end else if (state_q == ST_END && m2m_q && !phase_q) begin
      temp_q <= din_s;
    end
  end

  // ----------------------------------------------------------------
  // pin drive registered from the next state, except the mask and the constant end level
  // ----------------------------------------------------------------
  always_comb begin
    xfer_d = (state_d == ST_ADR) || (state_d == ST_RD) || (state_d == ST_WR) ||
             (state_d == ST_WAIT) || (state_d == ST_END);
    typ_d = I_TYPE[chan_d];
    rd_on = (state_d == ST_RD) || (state_d == ST_WR) || (state_d == ST_WAIT);
    wr_on = (state_d == ST_WR) || (state_d == ST_WAIT) ||
            (state_d == ST_RD && (I_EXT_WRITE || (I_COMPRESSED && !m2m_d)));
    addr_out = (state_q == ST_END && act_d == act_q) ? addr_nxt : cur_addr_q[act_d];
    // an end pulse seen in the last read state still ends this word
    tc_pred = (state_d == ST_END) && !(m2m_d && !phase_d) &&
              ((cur_cnt_q[act_d] == CNT_LAST) || eop_seen_q ||
               ((state_q == ST_ADR || state_q == ST_RD) && !eop_s));
  end

  // bus control and strobes
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_HOLD_REQ <= 1'b0;
      O_ADDR_EN <= 1'b0;
      O_ADDR_STB <= 1'b0;
      O_CH_ACK <= 4'h0;
      O_ADDR_LO_OE <= 1'b0;
      O_STROBE_OE <= 1'b0;
      {O_MEM_RD_B, O_MEM_WR_B, O_IO_RD_B, O_IO_WR_B} <= 4'hf;
    end else begin
      O_HOLD_REQ <= state_d != ST_IDLE;
      O_ADDR_EN <= xfer_d;
      O_ADDR_STB <= state_d == ST_ADR;
      O_CH_ACK <= ((xfer_d && !m2m_d) || state_d == ST_CASC) ? 4'h1 << chan_d : 4'h0;
      O_ADDR_LO_OE <= xfer_d;
      O_STROBE_OE <= xfer_d;
      if (m2m_d) begin
        O_MEM_RD_B <= !(rd_on && !phase_d);
        O_MEM_WR_B <= !(wr_on && phase_d);
        O_IO_RD_B <= 1'b1;
        O_IO_WR_B <= 1'b1;
      end else begin
        O_MEM_RD_B <= !(rd_on && typ_d == TYP_READ);
        O_IO_WR_B <= !(wr_on && typ_d == TYP_READ);
        O_MEM_WR_B <= !(wr_on && typ_d == TYP_WRITE);
        O_IO_RD_B <= !(rd_on && typ_d == TYP_WRITE);
      end
    end
  end

  // address byte, data bus and end pin
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_ADDR_LO <= BYTE_RST;
      O_DATA_OUT <= BYTE_RST;
      O_DATA_OE <= 1'b0;
      O_EOP_OE <= 1'b0;
      O_TERMINAL_COUNT <= 1'b0;
    end else begin
      O_ADDR_LO <= addr_out[7:0];
      O_DATA_OUT <= (state_d == ST_ADR) ? addr_out[15:8] : temp_q;
      O_DATA_OE <= (state_d == ST_ADR) || (xfer_d && m2m_d && phase_d);
      O_EOP_OE <= tc_pred;
      O_TERMINAL_COUNT <= tc_pred;
    end
  end

  assign O_EOP_OUT = 1'b0;
  assign O_MASK = mask_q;

endmodule

//--- tb/dts_props.sv
`timescale 1ns/10ps
module dts_props (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  input wire logic I_EXT_WRITE,
  input wire logic I_COMPRESSED,
  input wire logic I_MEM2MEM,
  input wire logic I_HOLD_GRANT,
  input wire logic O_HOLD_REQ,
  input wire logic O_ADDR_EN,
  input wire logic O_ADDR_STB,
  input wire logic [dts_pkg::CH_N-1:0] O_CH_ACK,
  input wire logic O_DATA_OE,
  input wire logic O_MEM_RD_B,
  input wire logic O_MEM_WR_B,
  input wire logic O_IO_RD_B,
  input wire logic O_IO_WR_B,
  input wire logic O_STROBE_OE,
  input wire logic O_EOP_OE,
  input wire logic O_TERMINAL_COUNT
);
  // ----------------------------------------
  // sequencer checks, one clock domain
  // ----------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);
  addr_latch_a: assert property (O_ADDR_STB |-> O_ADDR_EN && O_DATA_OE) else $error("latch strobe without address");
  stb_pulse_a: assert property (O_ADDR_STB |=> !O_ADDR_STB) else $error("latch strobe longer than one cycle");
  read_pair_a: assert property (!O_MEM_RD_B |-> O_IO_RD_B && O_MEM_WR_B) else $error("bad read strobe pair");
  write_pair_a: assert property (!O_IO_RD_B |-> O_MEM_RD_B && O_IO_WR_B) else $error("bad write strobe pair");
  write_lag_a: assert property (($fell(O_MEM_RD_B) && !I_EXT_WRITE && !I_COMPRESSED && !I_MEM2MEM)
    |-> O_IO_WR_B ##1 !O_IO_WR_B) else $error("write strobe not one state after read");
  early_write_a: assert property (($fell(O_IO_RD_B) && (I_EXT_WRITE || I_COMPRESSED)) |-> !O_MEM_WR_B)
    else $error("write strobe late");
  tc_pulse_a: assert property (O_TERMINAL_COUNT |-> O_EOP_OE ##1 !O_TERMINAL_COUNT) else $error("bad count pulse");
  idle_release_a: assert property ($fell(O_HOLD_REQ) |->
    !O_ADDR_EN && !O_STROBE_OE && !O_DATA_OE && O_CH_ACK == 4'h0) else $error("pins kept at idle");
  idle_gap_a: assert property ($fell(O_HOLD_REQ) |=> !O_HOLD_REQ) else $error("no idle state between grants");
  grant_wait_a: assert property (($rose(O_HOLD_REQ) && !I_HOLD_GRANT) |-> (!O_ADDR_EN)[*3])
    else $error("transfer before grant");
  ack_onehot_a: assert property ($onehot0(O_CH_ACK)) else $error("several acknowledges");
  tc_seen_c: cover property (O_TERMINAL_COUNT);
  latch_seen_c: cover property (O_ADDR_STB);
  hold_seen_c: cover property ($rose(O_HOLD_REQ));
endmodule
bind dts_top dts_props u_props (.*);

//--- tb/dts_far.sv
`timescale 1ns/10ps
module dts_far (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_hold_req,
  input wire logic i_mem_rd_b,
  input wire logic i_slow,
  input wire logic i_stall,
  output logic o_hold_grant,
  output logic o_ready,
  output logic [7:0] o_data
);
  logic [2:0] wait_q;
  logic [7:0] pat_q;
  // bus master: grants after a delay, takes the bus back as the request drops
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_q <= 3'h0;
      o_hold_grant <= 1'b0;
    end else if (!i_hold_req) begin
      wait_q <= 3'h0;
      o_hold_grant <= 1'b0;
    end else if (wait_q >= (i_slow ? 3'h5 : 3'h1)) begin
      o_hold_grant <= 1'b1;
    end else begin
      wait_q <= wait_q + 3'h1;
    end
  end
  // slow peripheral drops ready every other pair of cycles
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pat_q <= 8'h00;
      o_ready <= 1'b1;
    end else begin
      pat_q <= pat_q + 8'h01;
      o_ready <= !i_stall || pat_q[1];
    end
  end
  // memory answers a read strobe, otherwise the bus churns
  assign o_data = !i_mem_rd_b ? 8'hc3 : pat_q;
endmodule

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import dts_pkg::*;
  logic I_CORE_CLK = 1'b0, I_RST_B = 1'b0, I_ENABLE = 1'b1, I_PRIO_ROTATE = 1'b0, I_EXT_WRITE = 1'b0;
  logic I_COMPRESSED = 1'b0, I_MEM2MEM = 1'b0, I_PROG_WR = 1'b0, I_MASK_WR = 1'b0;
  logic eop_low = 1'b0, slow = 1'b0, stall = 1'b0;
  dts_type_t I_TYPE [CH_N] = '{default: TYP_READ};
  dts_mode_t I_MODE [CH_N] = '{default: MOD_SINGLE};
  logic [3:0] I_AUTO_INIT = 4'h0, I_ADDR_DEC = 4'h0, I_MASK_VAL = 4'h0, I_SW_REQ = 4'h0, I_CH_REQ = 4'h0;
  logic [1:0] I_PROG_CH = 2'h0;
  logic [15:0] I_PROG_ADDR = 16'h0000, I_PROG_COUNT = 16'h0000, rnd = 16'hc669, b;
  logic [15:0] a [4];
  logic I_HOLD_GRANT, I_READY, I_EOP_IN, O_HOLD_REQ, O_ADDR_EN, O_ADDR_STB, O_ADDR_LO_OE, O_DATA_OE;
  logic O_MEM_RD_B, O_MEM_WR_B, O_IO_RD_B, O_IO_WR_B, O_STROBE_OE, O_EOP_OUT, O_EOP_OE, O_TERMINAL_COUNT;
  logic [7:0] I_DATA_IN, O_ADDR_LO, O_DATA_OUT;
  logic [3:0] O_CH_ACK, O_MASK;
  logic [15:0] exp_q [$];
  int err_total = 0, tests_run = 0;
  logic strobe_seen = 1'b0;
  // ----------------------------------------
  // clock, end wire, design and far side
  // ----------------------------------------
  always #2.5 I_CORE_CLK = ~I_CORE_CLK;
  assign I_EOP_IN = ~(O_EOP_OE | eop_low); // open-drain end wire
  dts_top dut (.*);
  dts_far far (.i_clk(I_CORE_CLK), .i_rst_b(I_RST_B), .i_hold_req(O_HOLD_REQ), .i_mem_rd_b(O_MEM_RD_B),
    .i_slow(slow), .i_stall(stall), .o_hold_grant(I_HOLD_GRANT), .o_ready(I_READY), .o_data(I_DATA_IN));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic prog(input int ch, input dts_mode_t m, input dts_type_t t, input logic [15:0] ad, input logic [15:0] c);
    @(posedge I_CORE_CLK);
    I_PROG_WR <= 1'b1;
    I_PROG_CH <= ch[1:0];
    I_PROG_ADDR <= ad;
    I_PROG_COUNT <= c;
    I_MODE[ch] <= m;
    I_TYPE[ch] <= t;
    @(posedge I_CORE_CLK);
    I_PROG_WR <= 1'b0;
  endtask
  task automatic pulse(input logic is_mask, input logic [3:0] v);
    @(posedge I_CORE_CLK);
    if (is_mask) begin
      I_MASK_WR <= 1'b1;
      I_MASK_VAL <= v;
    end else begin
      I_SW_REQ <= v;
    end
    @(posedge I_CORE_CLK);
    I_MASK_WR <= 1'b0;
    I_SW_REQ <= 4'h0;
  endtask
  task automatic wait_ack(input logic [3:0] v);
    for (int i = 0; i < 300 && O_CH_ACK !== v; i++) @(posedge I_CORE_CLK);
    chk(O_CH_ACK, v);
  endtask
  task automatic drain(input string name);
    for (int i = 0; i < 4000 && exp_q.size() != 0; i++) @(posedge I_CORE_CLK);
    chk(16'(exp_q.size()), 16'h0);
    I_CH_REQ <= 4'h0;
    repeat (30) @(posedge I_CORE_CLK);
    $display("finished %s", name);
  endtask
  task automatic pri(input logic rot, input int first, input int rest [3]);
    I_PRIO_ROTATE <= rot;
    for (int c = 0; c < 4; c++) begin
      rnd = lfsr(rnd);
      a[c] = {rnd[15:8], 4'h1, rnd[3:0]};
      prog(c, MOD_SINGLE, dts_type_t'(c), a[c], 16'h0);
    end
    pulse(1'b1, 4'h0);
    I_CH_REQ <= 4'h1 << first;
    exp_q.push_back({4'h0, 4'h1 << first, a[first][7:0]});
    drain("lone channel");
    I_CH_REQ <= 4'hf;
    foreach (rest[i]) exp_q.push_back({4'h0, 4'h1 << rest[i], a[rest[i]][7:0]});
    drain("priority");
    chk(O_MASK, 4'hf);
  endtask
  // ----------------------------------------
  // result watcher: counts, data and strobes
  // ----------------------------------------
  always @(negedge I_CORE_CLK) begin
    if (O_TERMINAL_COUNT === 1'b1) chk({O_CH_ACK, O_ADDR_LO}, exp_q.size() ? exp_q.pop_front() : 16'hffff);
    if (I_MEM2MEM && O_MEM_WR_B === 1'b0) chk({O_CH_ACK, O_ADDR_EN, O_DATA_OUT}, {4'h0, 1'b1, 8'hc3});
    if ((O_MEM_RD_B & O_MEM_WR_B & O_IO_RD_B & O_IO_WR_B) !== 1'b1) strobe_seen = 1'b1;
  end
  // watchdog against a hung handshake
  initial begin
    #200000;
    err_total++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge I_CORE_CLK);
    I_RST_B <= 1'b1;
    repeat (3) @(posedge I_CORE_CLK);
    pri(1'b0, 1, '{0, 2, 3});
    pri(1'b1, 2, '{3, 0, 1});
    // block, decrementing across a high byte, compressed, stalled
    b = {rnd[15:8], 8'h02};
    {I_ADDR_DEC, I_COMPRESSED, stall, slow} <= {4'h2, 3'b111};
    prog(1, MOD_BLOCK, TYP_WRITE, b, 16'h0004);
    pulse(1'b1, 4'hd);
    I_CH_REQ <= 4'h2;
    exp_q.push_back({8'h02, 8'hfe});
    wait_ack(4'h2);
    I_CH_REQ <= 4'h0;
    drain("block");
    // verify by software request
    {I_ADDR_DEC, I_COMPRESSED} <= 5'h0;
    prog(2, MOD_BLOCK, TYP_VERIFY, b, 16'h0003);
    pulse(1'b1, 4'hb);
    strobe_seen = 1'b0;
    pulse(1'b0, 4'h4);
    exp_q.push_back({8'h04, b[7:0] + 8'h03});
    drain("verify");
    chk(strobe_seen, 1'b0);
    // demand, stopped and resumed
    I_EXT_WRITE <= 1'b1;
    prog(3, MOD_DEMAND, TYP_WRITE, a[3], 16'h0007);
    pulse(1'b1, 4'h7);
    exp_q.push_back({8'h08, a[3][7:0] + 8'h07});
    I_CH_REQ <= 4'h8;
    wait_ack(4'h8);
    repeat (6) @(posedge I_CORE_CLK);
    I_CH_REQ <= 4'h0;
    repeat (40) @(posedge I_CORE_CLK);
    chk({O_HOLD_REQ, 15'(exp_q.size())}, 16'h1);
    I_CH_REQ <= 4'h8;
    drain("demand");
    // auto initialization keeps the channel open
    I_AUTO_INIT <= 4'h1;
    prog(0, MOD_SINGLE, TYP_READ, a[0], 16'h0001);
    pulse(1'b1, 4'he);
    I_CH_REQ <= 4'h1;
    repeat (2) exp_q.push_back({8'h01, a[0][7:0] + 8'h01});
    drain("auto init");
    chk(O_MASK, 4'he);
    // memory to memory through the temporary byte
    I_AUTO_INIT <= 4'h0;
    prog(0, MOD_BLOCK, TYP_VERIFY, a[0], 16'h0001);
    prog(1, MOD_BLOCK, TYP_VERIFY, a[1], 16'h0001);
    pulse(1'b1, 4'hf);
    I_MEM2MEM <= 1'b1;
    pulse(1'b0, 4'h1);
    exp_q.push_back({8'h00, a[1][7:0] + 8'h01});
    drain("memory copy");
    // cascade ignores an external end pulse
    I_MEM2MEM <= 1'b0;
    prog(2, MOD_CASCADE, TYP_READ, b, 16'h0000);
    pulse(1'b1, 4'hb);
    I_CH_REQ <= 4'h4;
    wait_ack(4'h4);
    eop_low <= 1'b1;
    repeat (4) @(posedge I_CORE_CLK);
    eop_low <= 1'b0;
    repeat (4) @(posedge I_CORE_CLK);
    chk({O_CH_ACK, O_ADDR_EN, O_ADDR_STB, O_STROBE_OE, O_DATA_OE, O_ADDR_LO_OE}, {4'h4, 5'h0});
    drain("cascade");
    chk({O_HOLD_REQ, O_EOP_OUT}, 2'h0);
    // external end wire held low ends a block run on its first word
    prog(1, MOD_BLOCK, TYP_WRITE, b, 16'h0005);
    pulse(1'b1, 4'hd);
    eop_low <= 1'b1;
    I_CH_REQ <= 4'h2;
    exp_q.push_back({8'h02, b[7:0]});
    drain("external end");
    eop_low <= 1'b0;
    chk(O_MASK, 4'hf);
    conclude();
  end
endmodule
